// file: include/pmc_pkg.sv
/*
 * pmc_pkg: register offsets, field positions, reset values, divider codes
 * and timing counts shared by the power mode and clock manager.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package pmc_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_POWER_CONTROL = 4'h0;
	localparam logic [3:0] OFS_POWER_MANAGE = 4'h4;
	localparam logic [3:0] OFS_EXT_IRQ_FLAG = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;
	// power_control_reg fields
	localparam int BIT_IDLE_REQ = 0;
	localparam int BIT_PDOWN_REQ = 1;
	// power_manage_reg fields
	localparam int BIT_CLK_DIV_SEL_HI = 7;
	localparam int BIT_CLK_DIV_SEL_LO = 6;
	localparam int BIT_SWITCHBACK_EN = 5;
	localparam int BIT_CRYSTAL_AMP_OFF = 3;
	// ext_irq_flag_reg fields
	localparam int BIT_OSC_SOURCE_SEL = 3;
	localparam int BIT_RC_ACTIVE_IND = 2;
	localparam int BIT_RC_WAKE_SEL = 1;
	// status fields
	localparam int BIT_CRYSTAL_READY = 4;
	localparam int BIT_WDT_TIMEOUT = 0;
	// reset values
	localparam logic [1:0] RST_CLK_DIV = 2'h1;
	localparam logic RST_SWITCHBACK_EN = 1'b0;
	localparam logic RST_CRYSTAL_AMP_OFF = 1'b0;
	localparam logic RST_OSC_SOURCE_SEL = 1'b0;
	localparam logic RST_RC_WAKE_SEL = 1'b0;
	// divider codes
	localparam logic [1:0] DIV_RESERVED = 2'h0;
	localparam logic [1:0] DIV_4 = 2'h1;
	localparam logic [1:0] DIV_64 = 2'h2;
	localparam logic [1:0] DIV_1024 = 2'h3;
	localparam int DIVW = 11;
	localparam logic [DIVW-1:0] DIV_4_LAST = 11'h003;
	localparam logic [DIVW-1:0] DIV_64_LAST = 11'h03f;
	localparam logic [DIVW-1:0] DIV_1024_LAST = 11'h3ff;
	// timing counts in clocks
	localparam logic [3:0] RST_MIN_CLKS = 4'h8;
	localparam logic [3:0] RST_HOLD_CLKS = 4'h8;
	localparam logic [9:0] WDT_RST_DELAY_LAST = 10'h1ff;
	localparam logic [1:0] IDLE_PERIPH_LAST = 2'h3;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// file: src/pmc_power_clock_mgr.sv
/*
 * pmc_power_clock_mgr: idle, economy and power-down control, machine-cycle
 * clock enables, oscillator source selection, crystal warm-up tracking,
 * switchback, a small watchdog and reset recognition, behind Avalon-MM.
 * Assumes one free-running clk; the core and peripherals use the enables,
 * and interrupt, serial and strobe signals are synchronous to clk.
 */
// Register access over Avalon-MM and the register addresses are this design's own decisions.
// Functional notes
// - idle request write enters idle right after that write completes
// - idle halts cpu enable, peripherals keep running at clock over four
// - idle drives both strobes high and freezes port pins
// - enabled interrupt in idle clears idle bit and wakes cpu
// - reset pin held eight clocks resets device, leaving idle immediately
// - watchdog runs in idle, timeout wakes, resets 512 clocks later
// - divide code selects 4, 64 or 1024 clocks per machine cycle
// - economy mode runs peripherals at the same reduced machine-cycle rate
// - new divide selection takes effect one machine cycle later
// - source select picks crystal or rc, indicator follows one machine cycle later
// - crystal-off stops amplifier while rc runs; clear it before crystal
// - crystal ready flag after warm-up; crystal select refused until then
// - switchback returns divider to four on serial or external interrupt
// - switchback triggers are start-bit edge with receiver enabled, transmit buffer write or external interrupt acknowledge
// - divide writes ignored while switchback enabled and serial busy
// - every reset source forces divide-by-4
// - power-down request stops clocks, strobes low, ports show latches
// - reset pin ends power-down; watchdog cannot since it is stopped
// - enabled level-triggered external interrupt low wakes from power-down
// - rc wake select wakes on rc then moves to crystal when ready
module pmc_power_clock_mgr #(
	parameter int XTAL_WARM_CLKS = 16384,
	parameter int WDT_INTERVAL_MC = 131072
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rst_pin,
	input wire logic por_event,
	input wire logic irq_wake,
	input wire logic [1:0] ext_int_n,
	input wire logic [1:0] ext_int_en,
	input wire logic [1:0] ext_int_level,
	input wire logic global_irq_en,
	input wire logic ext_irq_ack,
	input wire logic serial_rx_en,
	input wire logic serial_rx_fall,
	input wire logic serial_tx_load,
	input wire logic serial_busy,
	input wire logic wdt_enable,
	input wire logic wdt_reset_en,
	input wire logic wdt_restart,
	input wire logic ale_core,
	input wire logic prog_store_strobe_core,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic core_reset,
	output logic wake_pulse,
	output logic ale_out,
	output logic prog_store_strobe,
	output logic port_freeze,
	output logic port_drive_sfr,
	output logic wdt_irq,
	output logic crystal_amp_en,
	output logic rc_osc_en,
	output logic rc_active_ind
);
	localparam int WDTW = $clog2(WDT_INTERVAL_MC);
	localparam int XTW = $clog2(XTAL_WARM_CLKS);

	typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_PDOWN} pmc_mode_t;

	function automatic logic [pmc_pkg::DIVW-1:0] pmc_div_last(input logic [1:0] code);
		unique case (code)
			pmc_pkg::DIV_64: pmc_div_last = pmc_pkg::DIV_64_LAST;
			pmc_pkg::DIV_1024: pmc_div_last = pmc_pkg::DIV_1024_LAST;
			default: pmc_div_last = pmc_pkg::DIV_4_LAST;
		endcase
	endfunction

	pmc_mode_t mode_ff;
	logic [31:0] rdata_ff;
	logic [3:0] rst_cnt_ff, hold_cnt_ff;
	logic [1:0] sel_cd_ff, act_cd_ff, q4_cnt_ff;
	logic [pmc_pkg::DIVW-1:0] div_cnt_ff;
	logic [WDTW-1:0] wdt_cnt_ff;
	logic [9:0] wdt_dly_ff;
	logic [XTW-1:0] warm_cnt_ff;
	logic ack_ff, core_reset_ff, pend_cd_ff, swb_ff, wdt_flag_ff;
	logic osc_sel_ff, rc_act_ff, rc_wake_ff, rc_boot_ff, crystal_amp_off_ff, xrdy_ff;
	logic wake_ff, ale_ff, prog_store_strobe_ff, freeze_ff, drive_sfr_ff;

	logic [7:0] wd;
	logic [1:0] wr_cd;
	logic req, wr_fire, rst_seen, wdt_fire, rst_src, dev_rst;
	logic mc_tick, q4_tick, periph_tick, wdt_timeout;
	logic pd_wake, idle_wake, switchback, amp_on;

	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_ff;
	assign avs_readdata = rdata_ff;
	assign wr_fire = avs_write & ack_ff & avs_byteenable[0];
	assign wd = avs_writedata[7:0];
	assign wr_cd = {wd[pmc_pkg::BIT_CLK_DIV_SEL_HI], wd[pmc_pkg::BIT_CLK_DIV_SEL_LO]};

	// reset recognition and hold-off
	assign rst_seen = (rst_cnt_ff == pmc_pkg::RST_MIN_CLKS);
	assign wdt_fire = wdt_flag_ff & wdt_reset_en & (wdt_dly_ff == pmc_pkg::WDT_RST_DELAY_LAST);
	assign rst_src = rst_seen | por_event | wdt_fire;
	assign dev_rst = ~reset_n | rst_src;

	always_ff @(posedge clk) begin
		if (!reset_n || !rst_pin)
			rst_cnt_ff <= '0;
		else if (!rst_seen)
			rst_cnt_ff <= rst_cnt_ff + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (dev_rst) begin
			hold_cnt_ff <= pmc_pkg::RST_HOLD_CLKS;
			core_reset_ff <= 1'b1;
		end else begin
			if (hold_cnt_ff != '0)
				hold_cnt_ff <= hold_cnt_ff - 4'h1;
			core_reset_ff <= (hold_cnt_ff != '0);
		end
	end

	// power mode sequencing
	assign pd_wake = global_irq_en & (|(~ext_int_n & ext_int_en & ext_int_level));
	assign idle_wake = irq_wake | wdt_timeout;

	always_ff @(posedge clk) begin
		if (dev_rst) begin
			mode_ff <= PMC_RUN;
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= 1'b0;
			unique case (mode_ff)
				PMC_RUN: begin
					if (wr_fire && avs_address == pmc_pkg::OFS_POWER_CONTROL) begin
						if (wd[pmc_pkg::BIT_PDOWN_REQ])
							mode_ff <= PMC_PDOWN;
						else if (wd[pmc_pkg::BIT_IDLE_REQ])
							mode_ff <= PMC_IDLE;
					end
				end
				PMC_IDLE: begin
					if (idle_wake) begin
						mode_ff <= PMC_RUN;
						wake_ff <= 1'b1;
					end
				end
				PMC_PDOWN: begin
					if (pd_wake) begin
						mode_ff <= PMC_RUN;
						wake_ff <= 1'b1;
					end
				end
			endcase
		end
	end

	// machine-cycle divider
	assign mc_tick = (div_cnt_ff == pmc_div_last(act_cd_ff));
	assign q4_tick = (q4_cnt_ff == pmc_pkg::IDLE_PERIPH_LAST);
	assign periph_tick = (mode_ff == PMC_IDLE) ? q4_tick : (mc_tick & (mode_ff == PMC_RUN));
	assign switchback = swb_ff & ((serial_rx_en & serial_rx_fall) | serial_tx_load
		| ext_irq_ack);

	always_ff @(posedge clk) begin
		if (dev_rst || mc_tick)
			div_cnt_ff <= '0;
		else
			div_cnt_ff <= div_cnt_ff + 11'h001;
	end

	always_ff @(posedge clk) begin
		if (dev_rst)
			q4_cnt_ff <= '0;
		else
			q4_cnt_ff <= q4_cnt_ff + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (dev_rst) begin
			sel_cd_ff <= pmc_pkg::RST_CLK_DIV;
			act_cd_ff <= pmc_pkg::RST_CLK_DIV;
			pend_cd_ff <= 1'b0;
			swb_ff <= pmc_pkg::RST_SWITCHBACK_EN;
			crystal_amp_off_ff <= pmc_pkg::RST_CRYSTAL_AMP_OFF;
		end else begin
			if (wr_fire && avs_address == pmc_pkg::OFS_POWER_MANAGE) begin
				swb_ff <= wd[pmc_pkg::BIT_SWITCHBACK_EN];
				crystal_amp_off_ff <= wd[pmc_pkg::BIT_CRYSTAL_AMP_OFF];
				if (!(swb_ff && serial_busy) && wr_cd != pmc_pkg::DIV_RESERVED
					&& wr_cd != sel_cd_ff) begin
					sel_cd_ff <= wr_cd;
					pend_cd_ff <= 1'b1;
				end
			end else if (pend_cd_ff && mc_tick) begin
				act_cd_ff <= sel_cd_ff;
				pend_cd_ff <= 1'b0;
			end
			if (switchback) begin
				sel_cd_ff <= pmc_pkg::DIV_4;
				act_cd_ff <= pmc_pkg::DIV_4;
				pend_cd_ff <= 1'b0;
			end
		end
	end

	// watchdog
	assign wdt_timeout = wdt_enable & periph_tick & (wdt_cnt_ff == WDTW'(WDT_INTERVAL_MC - 1));

	always_ff @(posedge clk) begin
		if (dev_rst || wdt_restart || wdt_timeout)
			wdt_cnt_ff <= '0;
		else if (wdt_enable && periph_tick)
			wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (dev_rst) begin
			wdt_flag_ff <= 1'b0;
			wdt_dly_ff <= '0;
		end else if (wdt_timeout) begin
			wdt_flag_ff <= 1'b1;
			// a repeat timeout must not re-arm a reset delay already running
			wdt_dly_ff <= (wdt_flag_ff && !wdt_restart) ? wdt_dly_ff + 10'h001 : '0;
		end else if (wdt_restart) begin
			wdt_flag_ff <= 1'b0;
			wdt_dly_ff <= '0;
		end else if (wdt_flag_ff && mode_ff != PMC_PDOWN) begin
			wdt_dly_ff <= wdt_dly_ff + 10'h001;
		end
	end

	// oscillator source and crystal warm-up
	assign amp_on = ~(crystal_amp_off_ff & rc_act_ff) & (mode_ff != PMC_PDOWN);

	always_ff @(posedge clk) begin
		if (dev_rst || !amp_on) begin
			warm_cnt_ff <= '0;
			xrdy_ff <= 1'b0;
		end else if (warm_cnt_ff == XTW'(XTAL_WARM_CLKS - 1)) begin
			xrdy_ff <= 1'b1;
		end else begin
			warm_cnt_ff <= warm_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (dev_rst) begin
			osc_sel_ff <= pmc_pkg::RST_OSC_SOURCE_SEL;
			rc_act_ff <= ~pmc_pkg::RST_OSC_SOURCE_SEL;
			rc_wake_ff <= pmc_pkg::RST_RC_WAKE_SEL;
			rc_boot_ff <= 1'b0;
		end else begin
			if (mode_ff == PMC_PDOWN && pd_wake && rc_wake_ff) begin
				osc_sel_ff <= 1'b0;
				rc_act_ff <= 1'b1;
				rc_boot_ff <= 1'b1;
			end else if (rc_boot_ff && xrdy_ff) begin
				osc_sel_ff <= 1'b1;
				rc_boot_ff <= 1'b0;
			end else if (wr_fire && avs_address == pmc_pkg::OFS_EXT_IRQ_FLAG) begin
				rc_wake_ff <= wd[pmc_pkg::BIT_RC_WAKE_SEL];
				if (!wd[pmc_pkg::BIT_OSC_SOURCE_SEL] || xrdy_ff)
					osc_sel_ff <= wd[pmc_pkg::BIT_OSC_SOURCE_SEL];
			end else if (mc_tick) begin
				rc_act_ff <= ~osc_sel_ff;
			end
		end
	end

	// pin control
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			ale_ff <= 1'b1;
			prog_store_strobe_ff <= 1'b1;
			freeze_ff <= 1'b0;
			drive_sfr_ff <= 1'b0;
		end else begin
			unique case (mode_ff)
				PMC_IDLE: begin
					ale_ff <= 1'b1;
					prog_store_strobe_ff <= 1'b1;
				end
				PMC_PDOWN: begin
					ale_ff <= 1'b0;
					prog_store_strobe_ff <= 1'b0;
				end
				default: begin
					ale_ff <= ale_core;
					prog_store_strobe_ff <= prog_store_strobe_core;
				end
			endcase
			freeze_ff <= (mode_ff == PMC_IDLE);
			drive_sfr_ff <= (mode_ff == PMC_PDOWN);
		end
	end

	// register bus
	always_ff @(posedge clk) begin
		if (!reset_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= req & ~ack_ff;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_ff <= pmc_pkg::READ_ZERO;
		end else if (avs_read && !ack_ff) begin
			rdata_ff <= pmc_pkg::READ_ZERO;
			unique case (avs_address)
				pmc_pkg::OFS_POWER_CONTROL: begin
					rdata_ff[pmc_pkg::BIT_IDLE_REQ] <= (mode_ff == PMC_IDLE);
					rdata_ff[pmc_pkg::BIT_PDOWN_REQ] <= (mode_ff == PMC_PDOWN);
				end
				pmc_pkg::OFS_POWER_MANAGE: begin
					rdata_ff[pmc_pkg::BIT_CLK_DIV_SEL_HI] <= sel_cd_ff[1];
					rdata_ff[pmc_pkg::BIT_CLK_DIV_SEL_LO] <= sel_cd_ff[0];
					rdata_ff[pmc_pkg::BIT_SWITCHBACK_EN] <= swb_ff;
					rdata_ff[pmc_pkg::BIT_CRYSTAL_AMP_OFF] <= crystal_amp_off_ff;
				end
				pmc_pkg::OFS_EXT_IRQ_FLAG: begin
					rdata_ff[pmc_pkg::BIT_OSC_SOURCE_SEL] <= osc_sel_ff;
					rdata_ff[pmc_pkg::BIT_RC_ACTIVE_IND] <= rc_act_ff;
					rdata_ff[pmc_pkg::BIT_RC_WAKE_SEL] <= rc_wake_ff;
				end
				pmc_pkg::OFS_STATUS: begin
					rdata_ff[pmc_pkg::BIT_CRYSTAL_READY] <= xrdy_ff;
					rdata_ff[pmc_pkg::BIT_WDT_TIMEOUT] <= wdt_flag_ff;
				end
				default: rdata_ff <= pmc_pkg::READ_ZERO;
			endcase
		end
	end

	// outputs
	assign cpu_clk_en = mc_tick & (mode_ff == PMC_RUN) & ~core_reset_ff;
	assign periph_clk_en = periph_tick;
	assign core_reset = core_reset_ff;
	assign wake_pulse = wake_ff;
	assign ale_out = ale_ff;
	assign prog_store_strobe = prog_store_strobe_ff;
	assign port_freeze = freeze_ff;
	assign port_drive_sfr = drive_sfr_ff;
	assign wdt_irq = wdt_flag_ff;
	assign crystal_amp_en = amp_on;
	assign rc_osc_en = (rc_act_ff | ~osc_sel_ff) & (mode_ff != PMC_PDOWN);
	assign rc_active_ind = rc_act_ff;
endmodule

// file: tb/pmc_power_clock_mgr_sva.sv
/* pmc_power_clock_mgr_sva: port-level checker for the power mode and clock manager.
   Assumes one clock and a synchronous active-low reset_n; bound below by name. */
module pmc_power_clock_mgr_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic rst_pin,
	input wire logic irq_wake,
	input wire logic [1:0] ext_int_n,
	input wire logic [1:0] ext_int_en,
	input wire logic [1:0] ext_int_level,
	input wire logic global_irq_en,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic core_reset,
	input wire logic wake_pulse,
	input wire logic ale_out,
	input wire logic prog_store_strobe,
	input wire logic port_freeze,
	input wire logic port_drive_sfr,
	input wire logic wdt_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_bus_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");
	a_idle_strobes_high: assert property (
		port_freeze && $past(port_freeze) && !$past(irq_wake) |-> ale_out && prog_store_strobe)
		else $error("strobes not high in idle");
	a_idle_cpu_halt: assert property (
		port_freeze && !$past(irq_wake) && !wdt_irq |-> !cpu_clk_en)
		else $error("cpu enable seen in idle");
	a_idle_irq_wake: assert property (
		port_freeze && irq_wake |-> ##[1:3] !port_freeze)
		else $error("idle not left on interrupt");
	a_pdown_strobes_low: assert property (
		port_drive_sfr && $past(port_drive_sfr) && $past(ext_int_n) == 2'h3
		|-> !ale_out && !prog_store_strobe)
		else $error("strobes not low in power-down");
	a_pdown_clocks_off: assert property (
		port_drive_sfr && $past(port_drive_sfr)
		&& !$past(global_irq_en && (|(~ext_int_n & ext_int_en & ext_int_level)))
		|-> !cpu_clk_en && !periph_clk_en)
		else $error("clock enable seen in power-down");
	a_pdown_pin_wake: assert property (
		port_drive_sfr && global_irq_en && (|(~ext_int_n & ext_int_en & ext_int_level))
		|-> ##[1:3] !port_drive_sfr)
		else $error("power-down not left on level interrupt");
	a_pin_reset_taken: assert property (
		rst_pin [*8] ##1 rst_pin |-> ##[0:2] core_reset)
		else $error("reset pin not recognised");
	a_reset_stops_cpu: assert property (
		core_reset |-> !cpu_clk_en)
		else $error("cpu enable during core reset");
	a_wake_one_cycle: assert property (
		wake_pulse |=> !wake_pulse)
		else $error("wake pulse longer than one cycle");
	c_idle_exit: cover property (port_freeze ##1 !port_freeze);
	c_pdown_exit: cover property (port_drive_sfr ##1 !port_drive_sfr);
	c_core_reset: cover property ($rose(core_reset));
endmodule
bind pmc_power_clock_mgr pmc_power_clock_mgr_sva u_sva (
	.clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .rst_pin(rst_pin), .irq_wake(irq_wake),
	.ext_int_n(ext_int_n), .ext_int_en(ext_int_en), .ext_int_level(ext_int_level),
	.global_irq_en(global_irq_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
	.core_reset(core_reset), .wake_pulse(wake_pulse), .ale_out(ale_out),
	.prog_store_strobe(prog_store_strobe), .port_freeze(port_freeze),
	.port_drive_sfr(port_drive_sfr), .wdt_irq(wdt_irq));

// file: tb/pmc_power_clock_mgr_tb.sv
/* pmc_power_clock_mgr_tb: self-checking bench driving the manager's ports directly.
   Assumes short warm-up and watchdog parameters; registers reached over Avalon-MM. */
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module pmc_power_clock_mgr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic rst_pin = 1'b0;
	logic irq_wake = 1'b0;
	logic [1:0] ext_int_n = 2'h3;
	logic global_irq_en = 1'b1;
	logic ext_irq_ack = 1'b0;
	logic serial_rx_en = 1'b0;
	logic serial_rx_fall = 1'b0;
	logic serial_tx_load = 1'b0;
	logic serial_busy = 1'b0;
	logic wdt_enable = 1'b0;
	logic wdt_reset_en = 1'b0;
	logic ale_core = 1'b0;
	logic prog_store_strobe_core = 1'b0;
	logic [1:0] ext_int_en = 2'h1;
	logic [1:0] ext_int_level = 2'h1;
	logic seen_wake = 1'b0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, cpu_clk_en, periph_clk_en, core_reset, wake_pulse, ale_out;
	logic prog_store_strobe, port_freeze, port_drive_sfr, wdt_irq, crystal_amp_en, rc_active_ind;
	logic [7:0] wv [6] = '{8'h40, 8'h80, 8'h40, 8'hc0, 8'h00, 8'h40};
	int ev [6] = '{4, 64, 4, 1024, 1024, 4};
	int failures = 0;
	int comparisons = 0;
	int cyc = 0;
	int per, np;
	pmc_power_clock_mgr #(.XTAL_WARM_CLKS(16), .WDT_INTERVAL_MC(8)) DUT (
		.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rst_pin(rst_pin),
		.por_event(1'b0), .irq_wake(irq_wake), .ext_int_n(ext_int_n), .ext_int_en(ext_int_en),
		.ext_int_level(ext_int_level), .global_irq_en(global_irq_en), .ext_irq_ack(ext_irq_ack),
		.serial_rx_en(serial_rx_en), .serial_rx_fall(serial_rx_fall),
		.serial_tx_load(serial_tx_load), .serial_busy(serial_busy), .wdt_enable(wdt_enable),
		.wdt_reset_en(wdt_reset_en), .wdt_restart(1'b0), .ale_core(ale_core),
		.prog_store_strobe_core(prog_store_strobe_core), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en),
		.core_reset(core_reset), .wake_pulse(wake_pulse), .ale_out(ale_out),
		.prog_store_strobe(prog_store_strobe), .port_freeze(port_freeze),
		.port_drive_sfr(port_drive_sfr), .wdt_irq(wdt_irq), .crystal_amp_en(crystal_amp_en),
		.rc_osc_en(), .rc_active_ind(rc_active_ind));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (wake_pulse === 1'b1)
			seen_wake = 1'b1;
		if (cyc > 60000) begin
			failures++;
			complete_run();
		end
	end
	task complete_run();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h00_0000, d};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rchk(input logic [3:0] a, input logic [7:0] e, input string n);
		bus(1'b0, a, 8'h00);
		`CHK(n, {24'h00_0000, e}, rd)
	endtask
	// cycles between two cpu enables, and peripheral ticks among them
	task measure();
		per = 0;
		np = 0;
		@(negedge clk);
		while (cpu_clk_en !== 1'b1)
			@(negedge clk);
		do begin
			@(negedge clk);
			per++;
			np += int'(periph_clk_en === 1'b1);
		end while (cpu_clk_en !== 1'b1 && per < 2000);
	endtask
	task count16();
		per = 0;
		np = 0;
		repeat (16) begin
			@(negedge clk);
			per += int'(cpu_clk_en === 1'b1);
			np += int'(periph_clk_en === 1'b1);
		end
	endtask
	task wait_core_run();
		per = 0;
		while (core_reset !== 1'b0 && per < 60) begin
			@(posedge clk);
			per++;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rchk(4'hc, 8'h00, "status early");
		bus(1'b1, 4'h8, 8'h08);
		rchk(4'h8, 8'h04, "source refused");
		rchk(4'h4, 8'h40, "manage reset");
		rchk(4'h0, 8'h00, "mode reset");
		rchk(4'h2, 8'h00, "unmapped");
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 4'h4, wv[i]);
			measure();
			measure();
			`CHK("clocks per cycle", ev[i], per)
			`CHK("periph per cycle", 1, np)
			rchk(4'h4, (wv[i] == 8'h00) ? 8'hc0 : wv[i], "divide field");
		end
		$display("test divider done");
		ale_core <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("run strobes", 2'h2, {ale_out, prog_store_strobe})
		ale_core <= 1'b0;
		bus(1'b1, 4'h0, 8'h01);
		repeat (2) @(posedge clk);
		`CHK("idle freeze", 1'b1, port_freeze)
		`CHK("idle strobes", 2'h3, {ale_out, prog_store_strobe})
		count16();
		`CHK("idle cpu ticks", 0, per)
		`CHK("idle periph ticks", 4, np)
		rchk(4'h0, 8'h01, "mode idle");
		irq_wake <= 1'b1;
		repeat (4) @(posedge clk);
		irq_wake <= 1'b0;
		`CHK("idle left", 1'b0, port_freeze)
		`CHK("wake pulse", 1'b1, seen_wake)
		rchk(4'h0, 8'h00, "idle bit cleared");
		$display("test idle done");
		{ale_core, prog_store_strobe_core} <= 2'h3;
		bus(1'b1, 4'h8, 8'h02);
		bus(1'b1, 4'h0, 8'h02);
		repeat (2) @(posedge clk);
		`CHK("pdown drive", 1'b1, port_drive_sfr)
		`CHK("pdown strobes", 3'h0, {ale_out, prog_store_strobe, crystal_amp_en})
		global_irq_en <= 1'b0;
		ext_int_n <= 2'h2;
		count16();
		`CHK("pdown ticks", 0, per + np)
		`CHK("no wake masked", 1'b1, port_drive_sfr)
		global_irq_en <= 1'b1;
		ext_int_en <= 2'h2;
		repeat (4) @(posedge clk);
		`CHK("no wake disabled", 1'b1, port_drive_sfr)
		ext_int_en <= 2'h1;
		ext_int_level <= 2'h0;
		repeat (4) @(posedge clk);
		`CHK("no wake edge", 1'b1, port_drive_sfr)
		ext_int_level <= 2'h1;
		repeat (4) @(posedge clk);
		ext_int_n <= 2'h3;
		`CHK("pdown left", 1'b0, port_drive_sfr)
		rchk(4'h0, 8'h00, "pdown bit cleared");
		$display("test power-down done");
		repeat (20) @(posedge clk);
		rchk(4'hc, 8'h10, "crystal ready");
		rchk(4'h8, 8'h0a, "rc wake switch");
		bus(1'b1, 4'h8, 8'h08);
		measure();
		rchk(4'h8, 8'h08, "crystal source");
		`CHK("rc indicator", 1'b0, rc_active_ind)
		bus(1'b1, 4'h8, 8'h00);
		measure();
		bus(1'b1, 4'h4, 8'h48);
		@(negedge clk);
		`CHK("amp off on rc", 1'b0, crystal_amp_en)
		bus(1'b1, 4'h4, 8'h40);
		@(negedge clk);
		`CHK("amp back on", 1'b1, crystal_amp_en)
		$display("test source done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 4'h4, 8'ha0);
			serial_rx_en <= (i == 1);
			serial_rx_fall <= (i < 2);
			serial_tx_load <= (i == 2);
			ext_irq_ack <= (i == 3);
			@(posedge clk);
			{serial_rx_fall, serial_tx_load, ext_irq_ack} <= 3'h0;
			rchk(4'h4, (i == 0) ? 8'ha0 : 8'h60, "switchback");
		end
		serial_busy <= 1'b1;
		bus(1'b1, 4'h4, 8'ha0);
		rchk(4'h4, 8'h60, "busy write");
		serial_busy <= 1'b0;
		$display("test switchback done");
		bus(1'b1, 4'h4, 8'h80);
		bus(1'b1, 4'h0, 8'h01);
		rst_pin <= 1'b1;
		repeat (7) @(posedge clk);
		rst_pin <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK("short pin", 2'h1, {core_reset, port_freeze})
		@(posedge clk);
		rst_pin <= 1'b1;
		repeat (10) @(posedge clk);
		rst_pin <= 1'b0;
		@(negedge clk);
		`CHK("pin reset", 2'h2, {core_reset, port_freeze})
		wait_core_run();
		rchk(4'h4, 8'h40, "pin divider");
		rchk(4'h0, 8'h00, "pin mode");
		$display("test reset pin done");
		bus(1'b1, 4'h4, 8'h80);
		wdt_enable <= 1'b1;
		wdt_reset_en <= 1'b1;
		bus(1'b1, 4'h0, 8'h01);
		per = 0;
		while (wdt_irq !== 1'b1 && per < 400) begin
			@(negedge clk);
			per++;
		end
		repeat (4) @(negedge clk);
		`CHK("wdt wake", 2'h2, {wdt_irq, port_freeze})
		per = 4;
		while (core_reset !== 1'b1 && per < 700) begin
			@(negedge clk);
			per++;
		end
		`CHK("wdt delay", 1'b1, per >= 510 && per <= 515)
		@(posedge clk);
		wdt_enable <= 1'b0;
		wait_core_run();
		rchk(4'h4, 8'h40, "wdt divider");
		$display("test watchdog done");
		complete_run();
	end
endmodule
